// ===== src/brightness_current_consts.svh
// Purpose: offsets, field positions, reset values for the brightness/current bank
// Assumes: byte-wide register port, offsets as byte addresses
// Notes:   definitions only
`ifndef BRIGHTNESS_CURRENT_CONSTS_SVH
`define BRIGHTNESS_CURRENT_CONSTS_SVH
`define ADDR_SHARED_BRT_HIGH   8'h00
`define ADDR_SHARED_BRT_LOW    8'h01
`define ADDR_SHARED_CUR_HIGH   8'h02
`define ADDR_SHARED_CUR_LOW    8'h03
`define ADDR_OUT2_BRT_HIGH     8'h04
`define ADDR_OUT2_BRT_LOW      8'h05
`define ADDR_OUT2_CUR          8'h06
`define ADDR_OUT3_BRT_HIGH     8'h07
`define ADDR_OUT3_BRT_LOW      8'h08
`define ADDR_OUT3_CUR          8'h09
`define ADDR_OUT4_BRT_HIGH     8'h0a
`define ADDR_OUT4_BRT_LOW      8'h0b
`define ADDR_OUT4_CUR          8'h0c
`define RESET_BYTE             8'h00
`define RESET_SHARED_BRT       16'h0000
`define RESET_CLUSTER_BRT      13'h0000
`define CLUSTER_HIGH_MSB       4
`define SHARED_CUR_HIGH_MSB    3
`define CLUSTER_BRT_SHIFT      3
`define SCALE_25MA             8'h19
`define SCALE_30MA             8'h1e
`define SCALE_50MA             8'h32
`define SCALE_60MA             8'h3c
`define SCALE_80MA             8'h50
`define SCALE_120MA            8'h78
`define SCALE_150MA            8'h96
`endif

// ===== src/brightness_current_pkg.sv
// Purpose: types for the brightness/current bank
// Assumes: nothing
// Notes:   constants live in the _consts header
package brightness_current_pkg;
    typedef logic [7:0]  reg_byte_t;
    typedef logic [15:0] shared_brt_t;
    typedef logic [12:0] cluster_brt_t;
    typedef logic [11:0] shared_cur_t;
    typedef logic [2:0]  scale_sel_t;
    typedef logic [7:0]  scale_ma_t;
endpackage

// ===== src/brightness_current_regs.sv
// Purpose: register bank for brightness and current of four LED outputs
// Assumes: byte write/read port from the serial interface, synchronous reset
// Notes:   brightness and shared current words commit on low-byte write, whole word in one cycle
`include "brightness_current_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module brightness_current_regs
    import brightness_current_pkg::*;
(
    input  wire logic                               clock,
    input  wire logic                               sys_rst,
    input  wire logic                               reg_write,
    input  wire logic [7:0]                         reg_addr,
    input  wire brightness_current_pkg::reg_byte_t  reg_wdata,
    output var brightness_current_pkg::reg_byte_t   reg_rdata,
    input  wire brightness_current_pkg::reg_byte_t  nonvolatile_word_0,
    input  wire brightness_current_pkg::reg_byte_t  nonvolatile_word_1,
    input  wire logic [3:0]                         display_mode,
    input  wire brightness_current_pkg::scale_sel_t full_scale_current_select,
    output var brightness_current_pkg::shared_brt_t out_brightness [4],
    output var brightness_current_pkg::shared_cur_t out_current [4],
    output var brightness_current_pkg::scale_ma_t   full_scale_ma
);
    import brightness_current_pkg::*;

    // full-scale current in mA for a select code; 110 unlisted, falls to lowest
    function automatic scale_ma_t scale_lookup(input scale_sel_t sel);
        case (sel)
            3'b000:  scale_lookup = `SCALE_25MA;
            3'b001:  scale_lookup = `SCALE_30MA;
            3'b010:  scale_lookup = `SCALE_50MA;
            3'b011:  scale_lookup = `SCALE_60MA;
            3'b100:  scale_lookup = `SCALE_80MA;
            3'b101:  scale_lookup = `SCALE_120MA;
            3'b111:  scale_lookup = `SCALE_150MA;
            default: scale_lookup = `SCALE_25MA;
        endcase
    endfunction

    // cluster brightness widened to the 16-bit output scale
    function automatic shared_brt_t widen(input cluster_brt_t b);
        widen = {b, 3'b000};
    endfunction

    // pending high bytes (readable) and committed words
    reg_byte_t    shared_brt_high;
    reg_byte_t    shared_brt_low;
    shared_brt_t  shared_out1_brightness;
    reg_byte_t    shared_cur_high;
    reg_byte_t    shared_cur_low;
    shared_cur_t  shared_out1_current;
    reg_byte_t    cl_brt_high [3];
    reg_byte_t    cl_brt_low [3];
    cluster_brt_t cl_brightness [3];
    reg_byte_t    cl_current [3];
    logic         nv_loaded;
    reg_byte_t    rdata_q;

    reg_byte_t    next_shared_brt_high;
    reg_byte_t    next_shared_brt_low;
    shared_brt_t  next_shared_out1_brightness;
    reg_byte_t    next_shared_cur_high;
    reg_byte_t    next_shared_cur_low;
    shared_cur_t  next_shared_out1_current;
    reg_byte_t    next_cl_brt_high [3];
    reg_byte_t    next_cl_brt_low [3];
    cluster_brt_t next_cl_brightness [3];
    reg_byte_t    next_cl_current [3];
    logic         next_nv_loaded;
    reg_byte_t    next_rdata;

    // register write decode and commit
    always_comb begin
        next_shared_brt_high        = shared_brt_high;
        next_shared_brt_low         = shared_brt_low;
        next_shared_out1_brightness = shared_out1_brightness;
        next_shared_cur_high        = shared_cur_high;
        next_shared_cur_low         = shared_cur_low;
        next_shared_out1_current    = shared_out1_current;
        next_cl_brt_high            = cl_brt_high;
        next_cl_brt_low             = cl_brt_low;
        next_cl_brightness          = cl_brightness;
        next_cl_current             = cl_current;
        next_nv_loaded              = 1'b1;
        if (!nv_loaded) begin
            // first cycle after reset: take current from nonvolatile words
            next_shared_cur_high     = {4'h0, nonvolatile_word_0[`SHARED_CUR_HIGH_MSB:0]};
            next_shared_cur_low      = nonvolatile_word_1;
            next_shared_out1_current = {nonvolatile_word_0[`SHARED_CUR_HIGH_MSB:0],
                                        nonvolatile_word_1};
        end else if (reg_write) begin
            case (reg_addr)
                `ADDR_SHARED_BRT_HIGH: begin
                    next_shared_brt_high = reg_wdata;
                end
                `ADDR_SHARED_BRT_LOW: begin
                    next_shared_brt_low         = reg_wdata;
                    next_shared_out1_brightness = {shared_brt_high, reg_wdata};
                end
                `ADDR_SHARED_CUR_HIGH: begin
                    next_shared_cur_high = {4'h0, reg_wdata[`SHARED_CUR_HIGH_MSB:0]};
                end
                `ADDR_SHARED_CUR_LOW: begin
                    next_shared_cur_low      = reg_wdata;
                    next_shared_out1_current = {shared_cur_high[`SHARED_CUR_HIGH_MSB:0],
                                                reg_wdata};
                end
                `ADDR_OUT2_BRT_HIGH: begin
                    next_cl_brt_high[0] = {3'b000, reg_wdata[`CLUSTER_HIGH_MSB:0]};
                end
                `ADDR_OUT2_BRT_LOW: begin
                    next_cl_brt_low[0]    = reg_wdata;
                    next_cl_brightness[0] = {cl_brt_high[0][`CLUSTER_HIGH_MSB:0],
                                             reg_wdata};
                end
                `ADDR_OUT2_CUR: begin
                    next_cl_current[0] = reg_wdata;
                end
                `ADDR_OUT3_BRT_HIGH: begin
                    next_cl_brt_high[1] = {3'b000, reg_wdata[`CLUSTER_HIGH_MSB:0]};
                end
                `ADDR_OUT3_BRT_LOW: begin
                    next_cl_brt_low[1]    = reg_wdata;
                    next_cl_brightness[1] = {cl_brt_high[1][`CLUSTER_HIGH_MSB:0],
                                             reg_wdata};
                end
                `ADDR_OUT3_CUR: begin
                    next_cl_current[1] = reg_wdata;
                end
                `ADDR_OUT4_BRT_HIGH: begin
                    next_cl_brt_high[2] = {3'b000, reg_wdata[`CLUSTER_HIGH_MSB:0]};
                end
                `ADDR_OUT4_BRT_LOW: begin
                    next_cl_brt_low[2]    = reg_wdata;
                    next_cl_brightness[2] = {cl_brt_high[2][`CLUSTER_HIGH_MSB:0],
                                             reg_wdata};
                end
                `ADDR_OUT4_CUR: begin
                    next_cl_current[2] = reg_wdata;
                end
                default: begin
                    next_nv_loaded = 1'b1; // unmapped write ignored
                end
            endcase
        end
    end

    // read mux, registered; unmapped reads give zero
    always_comb begin
        case (reg_addr)
            `ADDR_SHARED_BRT_HIGH: next_rdata = shared_brt_high;
            `ADDR_SHARED_BRT_LOW:  next_rdata = shared_brt_low;
            `ADDR_SHARED_CUR_HIGH: next_rdata = shared_cur_high;
            `ADDR_SHARED_CUR_LOW:  next_rdata = shared_cur_low;
            `ADDR_OUT2_BRT_HIGH:   next_rdata = cl_brt_high[0];
            `ADDR_OUT2_BRT_LOW:    next_rdata = cl_brt_low[0];
            `ADDR_OUT2_CUR:        next_rdata = cl_current[0];
            `ADDR_OUT3_BRT_HIGH:   next_rdata = cl_brt_high[1];
            `ADDR_OUT3_BRT_LOW:    next_rdata = cl_brt_low[1];
            `ADDR_OUT3_CUR:        next_rdata = cl_current[1];
            `ADDR_OUT4_BRT_HIGH:   next_rdata = cl_brt_high[2];
            `ADDR_OUT4_BRT_LOW:    next_rdata = cl_brt_low[2];
            `ADDR_OUT4_CUR:        next_rdata = cl_current[2];
            default:               next_rdata = `RESET_BYTE;
        endcase
    end

    // state registers, all brightness zero at reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            shared_brt_high        <= `RESET_BYTE;
            shared_brt_low         <= `RESET_BYTE;
            shared_out1_brightness <= `RESET_SHARED_BRT;
            shared_cur_high        <= `RESET_BYTE;
            shared_cur_low         <= `RESET_BYTE;
            shared_out1_current    <= 12'h000;
            for (int i = 0; i < 3; i++) begin
                cl_brt_high[i]   <= `RESET_BYTE;
                cl_brt_low[i]    <= `RESET_BYTE;
                cl_brightness[i] <= `RESET_CLUSTER_BRT;
                cl_current[i]    <= `RESET_BYTE;
            end
            nv_loaded <= 1'b0;
            rdata_q   <= `RESET_BYTE;
        end else begin
            shared_brt_high        <= next_shared_brt_high;
            shared_brt_low         <= next_shared_brt_low;
            shared_out1_brightness <= next_shared_out1_brightness;
            shared_cur_high        <= next_shared_cur_high;
            shared_cur_low         <= next_shared_cur_low;
            shared_out1_current    <= next_shared_out1_current;
            cl_brt_high            <= next_cl_brt_high;
            cl_brt_low             <= next_cl_brt_low;
            cl_brightness          <= next_cl_brightness;
            cl_current             <= next_cl_current;
            nv_loaded              <= next_nv_loaded;
            rdata_q                <= next_rdata;
        end
    end

    assign reg_rdata = rdata_q;

    // effective per-output values, pure selection of committed words
    logic any_display;
    assign any_display = |display_mode;
    assign out_brightness[0] = display_mode[0] ? shared_out1_brightness
                             : widen(shared_out1_brightness[15:`CLUSTER_BRT_SHIFT]);
    assign out_current[0]    = shared_out1_current;
    for (genvar g = 1; g < 4; g++) begin : g_out
        assign out_brightness[g] = display_mode[0] ? shared_out1_brightness
                                 : widen(cl_brightness[g-1]);
        assign out_current[g]    = any_display ? shared_out1_current
                                 : {4'h0, cl_current[g-1]};
    end

    // full-scale current selected for every field
    assign full_scale_ma = scale_lookup(full_scale_current_select);
endmodule
`default_nettype wire

// ===== tb/brightness_current_props.sv
// Purpose: port-level checks for the brightness/current bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached to every instance of the bank by bind
`include "brightness_current_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module brightness_current_props
    import brightness_current_pkg::*;
(
    input wire logic                               clock,
    input wire logic                               sys_rst,
    input wire logic                               reg_write,
    input wire logic [7:0]                         reg_addr,
    input wire brightness_current_pkg::reg_byte_t  reg_wdata,
    input wire brightness_current_pkg::reg_byte_t  reg_rdata,
    input wire brightness_current_pkg::reg_byte_t  nonvolatile_word_0,
    input wire brightness_current_pkg::reg_byte_t  nonvolatile_word_1,
    input wire logic [3:0]                         display_mode,
    input wire brightness_current_pkg::scale_sel_t full_scale_current_select,
    input wire brightness_current_pkg::shared_brt_t out_brightness [4],
    input wire brightness_current_pkg::shared_cur_t out_current [4],
    input wire brightness_current_pkg::scale_ma_t  full_scale_ma
);
    scale_ma_t exp_ma;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // expected full-scale figure per select code
    always_comb begin
        case (full_scale_current_select)
            3'h1: exp_ma = `SCALE_30MA;
            3'h2: exp_ma = `SCALE_50MA;
            3'h3: exp_ma = `SCALE_60MA;
            3'h4: exp_ma = `SCALE_80MA;
            3'h5: exp_ma = `SCALE_120MA;
            3'h7: exp_ma = `SCALE_150MA;
            default: exp_ma = `SCALE_25MA;
        endcase
    end
    // commit and hold behaviour of the shared and cluster words, and the full-scale map
    a_shared_hold: assert property (
        (reg_write && reg_addr == 8'h00 && !$past(sys_rst)) ##1 $stable(display_mode)
        |-> $stable(out_brightness[0])) else $error("shared brightness moved on high byte");
    a_shared_commit: assert property (
        (reg_write && reg_addr == 8'h01 && !$past(sys_rst)) ##1 display_mode[0]
        |-> out_brightness[0][7:0] == $past(reg_wdata)) else $error("shared low not committed");
    a_display_all: assert property (
        display_mode[0] |-> out_brightness[1] == out_brightness[0]
        && out_brightness[3] == out_brightness[0]) else $error("display brightness not global");
    a_cluster_width: assert property (
        !display_mode[0] |-> out_brightness[0][2:0] == 3'h0 && out_brightness[2][2:0] == 3'h0)
        else $error("cluster brightness wider than 13 bits");
    a_out2_commit: assert property (
        (reg_write && reg_addr == 8'h05 && !$past(sys_rst)) ##1 !display_mode[0]
        |-> out_brightness[1][10:3] == $past(reg_wdata)) else $error("output 2 low not committed");
    a_cur_commit: assert property (
        (reg_write && reg_addr == 8'h03 && !$past(sys_rst))
        |=> out_current[0][7:0] == $past(reg_wdata)) else $error("shared current not committed");
    a_cur_shared: assert property (
        display_mode != 4'h0 |-> out_current[1] == out_current[0]
        && out_current[2] == out_current[0]) else $error("display current not global");
    a_nv_load: assert property (
        $past(sys_rst) |=> out_current[0] == {nonvolatile_word_0[3:0], nonvolatile_word_1})
        else $error("start-up current not from nonvolatile words");
    a_scale_map: assert property (
        full_scale_ma == exp_ma) else $error("full-scale figure wrong for select");
    // main scenarios reached
    c_shared_low: cover property (reg_write && reg_addr == 8'h01 && display_mode[0]);
    c_out2_low: cover property (reg_write && reg_addr == 8'h05);
    c_cur_low: cover property (reg_write && reg_addr == 8'h03);
endmodule
bind brightness_current_regs brightness_current_props u_props (.clock(clock),
    .sys_rst(sys_rst), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .nonvolatile_word_0(nonvolatile_word_0),
    .nonvolatile_word_1(nonvolatile_word_1), .display_mode(display_mode),
    .full_scale_current_select(full_scale_current_select), .out_brightness(out_brightness),
    .out_current(out_current), .full_scale_ma(full_scale_ma));
`default_nettype wire

// ===== tb/serial_host_model.sv
// Purpose: serial host writing and reading the bank byte by byte
// Assumes: one byte transfer per clock, read data one edge after address
// Notes:   released data line shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
    import brightness_current_pkg::*;
(
    input  wire logic                              clock,
    input  wire brightness_current_pkg::reg_byte_t reg_rdata,
    output var  logic                              reg_write,
    output var  logic [7:0]                        reg_addr,
    output var  brightness_current_pkg::reg_byte_t reg_wdata
);
    // idle bus at time zero
    initial begin
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // single byte write
    task automatic wr(input logic [7:0] a, input reg_byte_t d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // word write, high byte then low byte back to back
    task automatic wr16(input logic [7:0] a, input logic [15:0] w);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w[15:8];
        @(posedge clock);
        reg_addr <= a + 8'h01;
        reg_wdata <= w[7:0];
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~w[7:0];
        #1;
    endtask
    // read: address at one edge, data taken after the next
    task automatic rd(input logic [7:0] a, output reg_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        @(posedge clock);
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/brightness_current_regs_tb.sv
// Purpose: self-checking bench for the brightness/current bank
// Assumes: 40 MHz clock, reset held 12 cycles
// Notes:   expected values worked out here, never read back from outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module brightness_current_regs_tb;
    import brightness_current_pkg::*;
    logic        clock;
    logic        sys_rst;
    logic        reg_write;
    logic [7:0]  reg_addr;
    logic [3:0]  display_mode;
    reg_byte_t   reg_wdata, reg_rdata, rb, lo;
    scale_sel_t  scale_sel;
    scale_ma_t   full_ma;
    shared_brt_t brt [4];
    shared_cur_t cur [4];
    int          checks = 0;
    int          n_errors = 0;
    logic [7:0]  cl_base [3] = '{8'h04, 8'h07, 8'h0a};
    scale_ma_t   ma_tab [8] = '{8'h19, 8'h1e, 8'h32, 8'h3c, 8'h50, 8'h78, 8'h19, 8'h96};
    brightness_current_regs uut (.clock(clock), .sys_rst(sys_rst), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .nonvolatile_word_0(8'ha5), .nonvolatile_word_1(8'h3c), .display_mode(display_mode),
        .full_scale_current_select(scale_sel), .out_brightness(brt), .out_current(cur),
        .full_scale_ma(full_ma));
    serial_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // free-running clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic set_mode(input logic [3:0] m);
        @(posedge clock);
        display_mode <= m;
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (3000) @(posedge clock);
        n_errors++;
        close_out();
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        display_mode = 4'h0;
        scale_sel = 3'h0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        host.rd(8'h02, rb);
        `CHK(rb, 8'h05)
        host.rd(8'h03, rb);
        `CHK(rb, 8'h3c)
        for (int a = 0; a < 14; a++) begin
            if (a != 2 && a != 3) begin
                host.rd(8'(a), rb);
                `CHK(rb, 8'h00)
            end
        end
        foreach (cl_base[k]) begin
            lo = 8'(8'h10 * (k + 1));
            host.wr(cl_base[k], 8'hff);
            host.rd(cl_base[k], rb);
            `CHK(rb, 8'h1f)
            `CHK(brt[k + 1], 16'h0000)
            host.wr(cl_base[k] + 8'h01, lo);
            `CHK(brt[k + 1], {5'h1f, lo, 3'h0})
        end
        set_mode(4'h1);
        host.wr16(8'h00, 16'h1234);
        foreach (brt[k]) `CHK(brt[k], 16'h1234)
        set_mode(4'h0);
        `CHK(brt[0], 16'h1230)
        host.wr16(8'h02, 16'hf789);
        host.rd(8'h02, rb);
        `CHK(rb, 8'h07)
        `CHK(cur[0], 12'h789)
        host.wr(8'h02, 8'h03);
        `CHK(cur[0], 12'h789)
        host.wr(8'h03, 8'h00);
        `CHK(cur[0], 12'h300)
        host.wr(8'h06, 8'h5a);
        `CHK(cur[1], 12'h05a)
        host.wr(8'h0d, 8'h5a);
        host.rd(8'h0d, rb);
        `CHK(rb, 8'h00)
        set_mode(4'h4);
        `CHK(cur[1], 12'h300)
        foreach (ma_tab[s]) begin
            @(posedge clock);
            scale_sel <= 3'(s);
            #1;
            `CHK(full_ma, ma_tab[s])
        end
        close_out();
    end
endmodule
`default_nettype wire
